// ==== core/pfc_regs_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the pixel fix register bank.
`ifndef PFC_REGS_DEFS_SVH
`define PFC_REGS_DEFS_SVH
`define PFC_OFS_CONTROL 12'h000
`define PFC_OFS_STATUS 12'h004
`define PFC_OFS_ERROR 12'h008
`define PFC_OFS_IRQ_MASK 12'h00c
`define PFC_OFS_VERSION 12'h010
`define PFC_OFS_FRAME_CNT 12'h014
`define PFC_OFS_LINE_CNT 12'h018
`define PFC_OFS_PIXEL_CNT 12'h01c
`define PFC_OFS_DIMENSIONS 12'h020
`define PFC_OFS_TEMPORAL 12'h100
`define PFC_OFS_SPATIAL 12'h104
`define PFC_OFS_AGE 12'h108
`define PFC_OFS_CANDIDATES 12'h10c
`define PFC_OFS_CORRECTED 12'h120
`define PFC_CTRL_RUN 0
`define PFC_CTRL_COMMIT 1
`define PFC_CTRL_BYPASS 4
`define PFC_CTRL_PATTERN 5
`define PFC_CTRL_FRAME_RESET 30
`define PFC_CTRL_SOFT_RESET 31
`define PFC_STAT_BEGUN 0
`define PFC_STAT_DONE 1
`define PFC_STAT_FAULT 16
`define PFC_CTRL_MASK 32'hc0000033
`define PFC_STAT_MASK 32'h00010003
`define PFC_ERR_MASK 32'h0000000f
`define PFC_IRQ_MASK_BITS 32'h0001ffff
`define PFC_DIM_MASK 32'h1fff1fff
`define PFC_TEMPORAL_MASK 32'h00000fff
`define PFC_HALF_MASK 32'h0000ffff
// Value is arbitrary, not a maker code.
`define PFC_VERSION_VALUE 32'h01020300
`define PFC_DIM_RESET 32'h01e00280
`define PFC_TEMPORAL_RESET 32'h00000010
`define PFC_SPATIAL_RESET 32'h00000040
`define PFC_AGE_RESET 32'h00000008
`define PFC_RESP_OKAY 2'h0
`define PFC_RESET_SYNC_STAGES 2
`endif

// ==== core/pfc_regs_pkg.sv ====
// Types of the pixel fix register bank.
package pfc_regs_pkg;
   typedef enum logic [1:0] {PFC_W_IDLE, PFC_W_RESP} pfc_wstate_t;
   typedef enum logic [0:0] {PFC_R_IDLE, PFC_R_DATA} pfc_rstate_t;
   typedef struct packed {
      pfc_wstate_t wst;
      pfc_rstate_t rst;
      logic awready;
      logic wready;
      logic arready;
      logic bvalid;
      logic rvalid;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [31:0] stat;
      logic [31:0] err;
      logic [31:0] irq_en;
      logic [31:0] dim_shadow;
      logic [31:0] temporal_shadow;
      logic [31:0] spatial_shadow;
      logic [31:0] age_shadow;
      logic commit_req;
      logic irq;
   } pfc_bus_state_t;
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] commit_sync;
      logic [2:0] ack_tgl;
      logic [31:0] frames;
      logic [31:0] lines;
      logic [31:0] pixels;
      logic [31:0] dim;
      logic [31:0] temporal;
      logic [31:0] spatial;
      logic [31:0] age;
      logic [31:0] candidates;
      logic [31:0] corrected;
      logic [3:0] evt_tgl;
      logic frame_reset_done;
   } pfc_video_state_t;
endpackage

// ==== core/pfc_regs.sv ====
// AXI4-Lite register bank controlling and monitoring the defect corrector core.
`timescale 1ns/10ps
`include "pfc_regs_defs.svh"
// Functional notes
// R1 - Registers are reached only through AXI4-Lite reads and writes.
// R2 - Bus inputs sampled on rising bus clock; outputs change after it.
// R3 - Bus clock enable low freezes state and holds all bus outputs.
// R4 - Bus clock enable low ignores inputs except the active-low bus reset.
// R5 - Bus reset sampled low resets at next edge regardless of enable.
// R6 - Master holds bus reset synchronous and low at least 32 slow cycles.
// R7 - Bus reset is resynchronised into video domain and resets core too.
// R8 - Bus clock and enable never affect the video stream side.
// R9 - Address and data buses are 32 bits, responses are 2 bits.
// R10 - Control register: run, commit, bypass, pattern, frame reset, soft reset.
// R11 - Bypass, pattern and throughput counters exist only with debug option.
// R12 - Status holds frame begun, frame done and input fault summary.
// R13 - Error holds early/late end-of-line and early/late start-of-frame.
// R14 - Interrupt enable bits 16..0 match status bits.
// R15 - Read-only version register with five fields.
// R16 - Read-only frame, line and pixel counters reset to zero.
// R17 - Double-buffered frame dimensions: pixels 12..0, lines 28..16.
// R18 - Double-buffered temporal threshold in bits 11..0.
// R19 - Double-buffered spatial threshold in bits 15..0.
// R20 - Double-buffered outlier age threshold in bits 15..0.
// R21 - Read-only candidate count of previous frame, resets to zero.
// R22 - Read-only corrected pixel count of previous frame, resets to zero.
// R23 - Status and error flags are sticky; writing one clears that bit.
// R24 - Interrupt is OR of status bits ANDed with enable bits.
// R25 - Shadow values move to active copy at frame end when commit set.
// R26 - Every access answers OKAY; writes to read-only registers are ignored.
module pfc_regs
   import pfc_regs_pkg::*;
#(
   parameter bit DEBUG_FEATURES = 1'b1
)
(
   input wire logic s_axi_aclk,
   input wire logic s_axi_aclken,
   input wire logic s_axi_aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [31:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic irq,
   input wire logic aclk,
   input wire logic rst,
   input wire logic frame_start,
   input wire logic frame_end,
   input wire logic line_end,
   input wire logic pixel_done,
   input wire logic [3:0] input_fault,
   input wire logic [31:0] candidates_in,
   input wire logic [31:0] corrected_in,
   output logic core_reset,
   output logic core_run_bit,
   output logic bypass_mode,
   output logic pattern_mode,
   output logic [31:0] active_dimensions,
   output logic [31:0] active_temporal,
   output logic [31:0] active_spatial,
   output logic [31:0] active_age
);

////////////////////////////////////////////////////////////////////////////////
// Video clock domain. It never looks at the bus enable or at raw bus signals other than the bus reset.
pfc_bus_state_t b_q, b_d;
pfc_video_state_t v_q, v_d;
logic [1:0] evt_sync1_q [4];
logic [1:0] evt_sync2_q [4];
logic [3:0] evt_pulse;
logic [31:0] ctrl_sync1_q, ctrl_sync2_q;
logic [1:0] ack_sync_q;
logic [3:0] fault_sync1_q, fault_sync2_q;
logic core_reset_q, run_q, bypass_q, pattern_q;
wire logic vid_rst = v_q.rst_sync[1];

always_comb
begin
   v_d = v_q;
   if (v_q.commit_sync[1] && frame_end) // [R25]
   begin
      v_d.dim = b_q.dim_shadow; // [R17]
      v_d.temporal = b_q.temporal_shadow; // [R18]
      v_d.spatial = b_q.spatial_shadow; // [R19]
      v_d.age = b_q.age_shadow; // [R20]
   end
   v_d.commit_sync = {v_q.commit_sync[0], ctrl_sync2_q[`PFC_CTRL_COMMIT]};
   if (frame_end)
   begin
      v_d.candidates = candidates_in; // [R21]
      v_d.corrected = corrected_in; // [R22]
   end
   if (DEBUG_FEATURES) // [R11]
   begin
      v_d.frames = v_q.frames + 32'h1 * {31'h0, frame_end}; // [R16]
      v_d.lines = v_q.lines + {31'h0, line_end};
      v_d.pixels = v_q.pixels + {31'h0, pixel_done};
   end
   v_d.evt_tgl = v_q.evt_tgl ^ {|input_fault, frame_end, frame_start, 1'b0};
   v_d.frame_reset_done = ctrl_sync2_q[`PFC_CTRL_FRAME_RESET] & (frame_end | ~run_q);
   v_d.ack_tgl = {v_q.ack_tgl[1:0], v_q.frame_reset_done};
end

always_ff @(posedge aclk or posedge rst)
begin
   if (rst)
   begin
      v_q.rst_sync <= 2'h3;
      v_q.commit_sync <= 2'h0;
      v_q.ack_tgl <= 3'h0;
      v_q.frames <= 32'h0;
      v_q.lines <= 32'h0;
      v_q.pixels <= 32'h0;
      v_q.dim <= `PFC_DIM_RESET;
      v_q.temporal <= `PFC_TEMPORAL_RESET;
      v_q.spatial <= `PFC_SPATIAL_RESET;
      v_q.age <= `PFC_AGE_RESET;
      v_q.candidates <= 32'h0;
      v_q.corrected <= 32'h0;
      v_q.evt_tgl <= 4'h0;
      v_q.frame_reset_done <= 1'b0;
      core_reset_q <= 1'b1;
      run_q <= 1'b0;
      bypass_q <= 1'b0;
      pattern_q <= 1'b0;
   end
   else if (vid_rst) // [R7]
   begin
      // Bus reset crosses on two flip-flops; only the second stage is read.
      v_q.rst_sync <= {v_q.rst_sync[0], ~s_axi_aresetn}; // [R7]
      v_q.commit_sync <= 2'h0;
      v_q.frames <= 32'h0;
      v_q.lines <= 32'h0;
      v_q.pixels <= 32'h0;
      v_q.candidates <= 32'h0;
      v_q.corrected <= 32'h0;
      v_q.frame_reset_done <= 1'b0;
      core_reset_q <= 1'b1;
      run_q <= 1'b0;
      bypass_q <= 1'b0;
      pattern_q <= 1'b0;
   end
   else
   begin
      v_q.rst_sync <= {v_q.rst_sync[0], ~s_axi_aresetn}; // [R7]
      v_q.commit_sync <= v_d.commit_sync;
      v_q.ack_tgl <= v_d.ack_tgl;
      v_q.frames <= v_d.frames;
      v_q.lines <= v_d.lines;
      v_q.pixels <= v_d.pixels;
      v_q.dim <= v_d.dim;
      v_q.temporal <= v_d.temporal;
      v_q.spatial <= v_d.spatial;
      v_q.age <= v_d.age;
      v_q.candidates <= v_d.candidates;
      v_q.corrected <= v_d.corrected;
      v_q.evt_tgl <= v_d.evt_tgl;
      v_q.frame_reset_done <= v_d.frame_reset_done;
      core_reset_q <= ctrl_sync2_q[`PFC_CTRL_SOFT_RESET] | v_q.frame_reset_done;
      run_q <= ctrl_sync2_q[`PFC_CTRL_RUN];
      bypass_q <= DEBUG_FEATURES & ctrl_sync2_q[`PFC_CTRL_BYPASS]; // [R11]
      pattern_q <= DEBUG_FEATURES & ctrl_sync2_q[`PFC_CTRL_PATTERN];
   end
end

// Control levels cross on two flip-flops; they change seldom and only steer modes.
always_ff @(posedge aclk or posedge rst)
begin
   if (rst)
   begin
      ctrl_sync1_q <= 32'h0;
      ctrl_sync2_q <= 32'h0;
   end
   else
   begin
      ctrl_sync1_q <= b_q.ctrl; // [R8]
      ctrl_sync2_q <= ctrl_sync1_q;
   end
end

assign core_reset = core_reset_q;
assign core_run_bit = run_q;
assign bypass_mode = bypass_q;
assign pattern_mode = pattern_q;
assign active_dimensions = v_q.dim;
assign active_temporal = v_q.temporal;
assign active_spatial = v_q.spatial;
assign active_age = v_q.age;

////////////////////////////////////////////////////////////////////////////////
// Event toggles cross into the bus domain; a toggle change marks one event.
genvar gi;
generate
   for (gi = 0; gi < 4; gi++)
   begin : g_evt
      always_ff @(posedge s_axi_aclk or posedge rst)
      begin
         if (rst)
         begin
            evt_sync1_q[gi] <= 2'h0;
            evt_sync2_q[gi] <= 2'h0;
         end
         else
         begin
            evt_sync1_q[gi] <= {1'b0, v_q.evt_tgl[gi]};
            evt_sync2_q[gi] <= {evt_sync2_q[gi][0], evt_sync1_q[gi][0]};
         end
      end
      assign evt_pulse[gi] = evt_sync2_q[gi][1] ^ evt_sync2_q[gi][0];
   end
endgenerate

always_ff @(posedge s_axi_aclk or posedge rst)
begin
   if (rst)
      ack_sync_q <= 2'h0;
   else
      ack_sync_q <= {ack_sync_q[0], v_q.ack_tgl[2]};
end

// Fault levels cross on two flip-flops; the summary toggle takes a video edge longer, so they are settled when it lands.
always_ff @(posedge s_axi_aclk or posedge rst)
begin
   if (rst)
   begin
      fault_sync1_q <= 4'h0;
      fault_sync2_q <= 4'h0;
   end
   else
   begin
      fault_sync1_q <= input_fault;
      fault_sync2_q <= fault_sync1_q;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Bus domain: read mux and write decode.
function automatic logic [31:0] read_word(input logic [11:0] a);
   logic [31:0] r;
   r = 32'h0;
   if (a == `PFC_OFS_CONTROL) r = b_q.ctrl;
   else if (a == `PFC_OFS_STATUS) r = b_q.stat; // [R12]
   else if (a == `PFC_OFS_ERROR) r = b_q.err; // [R13]
   else if (a == `PFC_OFS_IRQ_MASK) r = b_q.irq_en; // [R14]
   else if (a == `PFC_OFS_VERSION) r = `PFC_VERSION_VALUE; // [R15]
   else if (a == `PFC_OFS_FRAME_CNT) r = v_q.frames; // [R16]
   else if (a == `PFC_OFS_LINE_CNT) r = v_q.lines;
   else if (a == `PFC_OFS_PIXEL_CNT) r = v_q.pixels;
   else if (a == `PFC_OFS_DIMENSIONS) r = b_q.dim_shadow;
   else if (a == `PFC_OFS_TEMPORAL) r = b_q.temporal_shadow;
   else if (a == `PFC_OFS_SPATIAL) r = b_q.spatial_shadow;
   else if (a == `PFC_OFS_AGE) r = b_q.age_shadow;
   else if (a == `PFC_OFS_CANDIDATES) r = v_q.candidates;
   else if (a == `PFC_OFS_CORRECTED) r = v_q.corrected;
   return r;
endfunction

always_comb
begin
   b_d = b_q;
   b_d.awready = 1'b0;
   b_d.wready = 1'b0;
   b_d.arready = 1'b0;
   // Clear by write first, hardware events afterwards so a same-cycle event wins.
   case (b_q.wst)
      PFC_W_IDLE:
      begin
         if (s_axi_awvalid && s_axi_wvalid) // [R1]
         begin
            b_d.awready = 1'b1;
            b_d.wready = 1'b1;
            b_d.wst = PFC_W_RESP;
            if (s_axi_awaddr[11:0] == `PFC_OFS_CONTROL)
               b_d.ctrl = s_axi_wdata & (DEBUG_FEATURES ? `PFC_CTRL_MASK : 32'hc0000003); // [R10] [R11]
            else if (s_axi_awaddr[11:0] == `PFC_OFS_STATUS)
               b_d.stat = b_q.stat & ~s_axi_wdata; // [R23]
            else if (s_axi_awaddr[11:0] == `PFC_OFS_ERROR)
               b_d.err = b_q.err & ~s_axi_wdata;
            else if (s_axi_awaddr[11:0] == `PFC_OFS_IRQ_MASK)
               b_d.irq_en = s_axi_wdata & `PFC_IRQ_MASK_BITS;
            else if (s_axi_awaddr[11:0] == `PFC_OFS_DIMENSIONS)
               b_d.dim_shadow = s_axi_wdata & `PFC_DIM_MASK;
            else if (s_axi_awaddr[11:0] == `PFC_OFS_TEMPORAL)
               b_d.temporal_shadow = s_axi_wdata & `PFC_TEMPORAL_MASK;
            else if (s_axi_awaddr[11:0] == `PFC_OFS_SPATIAL)
               b_d.spatial_shadow = s_axi_wdata & `PFC_HALF_MASK;
            else if (s_axi_awaddr[11:0] == `PFC_OFS_AGE)
               b_d.age_shadow = s_axi_wdata & `PFC_HALF_MASK; // [R26]
         end
      end
      default:
      begin
         // The response waits a cycle so it follows the completed address and data handshakes.
         if (!b_q.bvalid)
            b_d.bvalid = 1'b1;
         else if (s_axi_bready)
         begin
            b_d.bvalid = 1'b0;
            b_d.wst = PFC_W_IDLE;
         end
      end
   endcase
   case (b_q.rst)
      PFC_R_IDLE:
      begin
         if (s_axi_arvalid)
         begin
            b_d.arready = 1'b1;
            b_d.rdata = read_word(s_axi_araddr[11:0]);
            b_d.rst = PFC_R_DATA;
         end
      end
      default:
      begin
         if (!b_q.rvalid)
            b_d.rvalid = 1'b1;
         else if (s_axi_rready)
         begin
            b_d.rvalid = 1'b0;
            b_d.rst = PFC_R_IDLE;
         end
      end
   endcase
   if (ack_sync_q[1])
      b_d.ctrl[`PFC_CTRL_FRAME_RESET] = 1'b0;
   b_d.err = b_d.err | {28'h0, fault_sync2_q & {4{evt_pulse[3]}}}; // [R13]
   if (evt_pulse[1]) b_d.stat[`PFC_STAT_BEGUN] = 1'b1; // [R23]
   if (evt_pulse[2]) b_d.stat[`PFC_STAT_DONE] = 1'b1;
   if (evt_pulse[3]) b_d.stat[`PFC_STAT_FAULT] = 1'b1;
   b_d.commit_req = b_d.ctrl[`PFC_CTRL_COMMIT];
   b_d.irq = |(b_d.stat & b_d.irq_en); // [R24]
end

// Synchronous bus reset beats the enable; without enable all of b_q is held.
always_ff @(posedge s_axi_aclk)
begin
   if (!s_axi_aresetn) // [R5]
   begin
      b_q <= '0;
      b_q.dim_shadow <= `PFC_DIM_RESET;
      b_q.temporal_shadow <= `PFC_TEMPORAL_RESET;
      b_q.spatial_shadow <= `PFC_SPATIAL_RESET;
      b_q.age_shadow <= `PFC_AGE_RESET;
   end
   else if (s_axi_aclken) // [R2] [R3] [R4]
      b_q <= b_d;
end

assign s_axi_awready = b_q.awready;
assign s_axi_wready = b_q.wready;
assign s_axi_arready = b_q.arready;
assign s_axi_bvalid = b_q.bvalid;
assign s_axi_rvalid = b_q.rvalid;
assign s_axi_rdata = b_q.rdata;
assign s_axi_bresp = `PFC_RESP_OKAY; // [R9] [R26]
assign s_axi_rresp = `PFC_RESP_OKAY;
assign irq = b_q.irq;

////////////////////////////////////////////////////////////////////////////////
sequence bvalid_pending;
   s_axi_bvalid && !s_axi_bready;
endsequence

bresp_hold_a: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
   bvalid_pending |=> s_axi_bvalid) else $error("write response dropped early"); // [R1]
freeze_hold_a: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
   !s_axi_aclken |=> $stable(s_axi_rdata) && $stable(irq)) else $error("outputs moved while frozen"); // [R3]
reset_clears_a: assert property (@(posedge s_axi_aclk)
   !s_axi_aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("bus reset ignored"); // [R5]
okay_resp_a: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
   s_axi_rvalid |-> s_axi_rresp == 2'h0) else $error("read response not okay"); // [R26]
irq_or_a: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
   s_axi_aclken |=> irq == |(b_q.stat & b_q.irq_en)) else $error("interrupt wrong"); // [R24]
sticky_stat_a: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
   b_q.stat[0] && !(s_axi_awvalid && s_axi_wvalid) |=> b_q.stat[0]) else $error("status flag lost"); // [R23]
vid_reset_a: assert property (@(posedge aclk) disable iff (rst)
   vid_rst |=> core_reset && !core_run_bit) else $error("video side not reset"); // [R7]
commit_gate_a: assert property (@(posedge aclk) disable iff (rst)
   !v_q.commit_sync[1] && !vid_rst |=> $stable(active_dimensions)) else $error("uncommitted update"); // [R25]
endmodule

// ==== test/pfc_axi_master.sv ====
// Host-side AXI4-Lite master model that issues single reads and writes.
`timescale 1ns/10ps
module pfc_axi_master
(
   input wire logic clk,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic arvalid,
   input wire logic arready,
   output logic [31:0] araddr,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   initial
   begin
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      awaddr = 32'h0;
      wdata = 32'h0;
      araddr = 32'h0;
      bready = 1'b0;
      rready = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Released lines carry the inverse of their last value so a stale value cannot pass.
   task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(negedge clk);
      awaddr = a;
      wdata = d;
      awvalid = 1'b1;
      wvalid = 1'b1;
      n = 0;
      while (!(awready && wready) && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      awvalid = 1'b0;
      wvalid = 1'b0;
      awaddr = ~a;
      wdata = ~d;
      while (!bvalid && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      // One response edge is left unanswered so the slave must keep it standing.
      @(negedge clk);
      r = bvalid ? bresp : 2'h3;
      bready = 1'b1;
      @(negedge clk);
      bready = 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(negedge clk);
      araddr = a;
      arvalid = 1'b1;
      n = 0;
      while (!arready && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      arvalid = 1'b0;
      araddr = ~a;
      while (!rvalid && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      d = rdata;
      r = rvalid ? rresp : 2'h3;
      rready = 1'b1;
      @(negedge clk);
      rready = 1'b0;
   endtask
endmodule

// ==== test/pfc_regs_tb_top.sv ====
// Self-checking bench for the pixel fix register bank.
`timescale 1ns/10ps
`include "pfc_regs_defs.svh"
module pfc_regs_tb_top;
   logic sys_clk = 1'b0;
   logic aclk, rst, aclken, aresetn, irq, core_reset, run, bypass, pattern;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata, cand, corr, a_dim, a_tmp, a_spa, a_age;
   logic [1:0] bresp, rresp;
   logic [3:0] ev, fault;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #10 sys_clk = ~sys_clk;
   initial
   begin
      aclk = 1'b0;
      #3;
      forever #80 aclk = ~aclk;
   end
   pfc_regs #(.DEBUG_FEATURES(1'b1)) i_pfc_regs (.s_axi_aclk(sys_clk), .s_axi_aclken(aclken),
      .s_axi_aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .irq(irq), .aclk(aclk), .rst(rst), .frame_start(ev[0]), .frame_end(ev[1]),
      .line_end(ev[2]), .pixel_done(ev[3]), .input_fault(fault), .candidates_in(cand),
      .corrected_in(corr), .core_reset(core_reset), .core_run_bit(run), .bypass_mode(bypass),
      .pattern_mode(pattern), .active_dimensions(a_dim), .active_temporal(a_tmp),
      .active_spatial(a_spa), .active_age(a_age));
   pfc_axi_master i_pfc_axi_master (.clk(sys_clk), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic w(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      i_pfc_axi_master.wr({20'h0, a}, d, r);
      chk("write response", {30'h0, r}, 32'h0);
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      i_pfc_axi_master.rd({20'h0, a}, d, r);
      chk("read response", {30'h0, r}, 32'h0);
      chk(nm, d, exp);
   endtask
   task automatic vpulse(input int k, input int n);
      repeat (n)
      begin
         @(negedge aclk);
         ev[k] = 1'b1;
         @(negedge aclk);
         ev[k] = 1'b0;
      end
      // Events cross as toggles, so give them a few bus cycles to land.
      repeat (12) @(negedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      logic [11:0] ofs [15] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018,
         12'h01c, 12'h020, 12'h100, 12'h104, 12'h108, 12'h10c, 12'h120, 12'h200};
      logic [31:0] ex [15] = '{32'h0, 32'h0, 32'h0, 32'h0, `PFC_VERSION_VALUE, 32'h0, 32'h0, 32'h0,
         `PFC_DIM_RESET, `PFC_TEMPORAL_RESET, `PFC_SPATIAL_RESET, `PFC_AGE_RESET, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 15; i++)
         rchk("reset value", ofs[i], ex[i]);
      w(`PFC_OFS_VERSION, 32'h0);
      rchk("version after write", `PFC_OFS_VERSION, `PFC_VERSION_VALUE);
   endtask
   task automatic t_commit();
      w(`PFC_OFS_DIMENSIONS, 32'hffffffff);
      w(`PFC_OFS_TEMPORAL, 32'hffffffff);
      w(`PFC_OFS_SPATIAL, 32'hffffffff);
      w(`PFC_OFS_AGE, 32'hffffffff);
      rchk("dimensions", `PFC_OFS_DIMENSIONS, `PFC_DIM_MASK);
      rchk("temporal", `PFC_OFS_TEMPORAL, `PFC_TEMPORAL_MASK);
      rchk("spatial", `PFC_OFS_SPATIAL, `PFC_HALF_MASK);
      rchk("age", `PFC_OFS_AGE, `PFC_HALF_MASK);
      vpulse(1, 1);
      chk("held temporal", a_tmp, `PFC_TEMPORAL_RESET);
      w(`PFC_OFS_CONTROL, 32'h2);
      // The commit bit needs four video edges to cross.
      repeat (6) @(negedge aclk);
      vpulse(1, 1);
      chk("active dimensions", a_dim, `PFC_DIM_MASK);
      chk("active temporal", a_tmp, `PFC_TEMPORAL_MASK);
      chk("active spatial", a_spa, `PFC_HALF_MASK);
      chk("active age", a_age, `PFC_HALF_MASK);
   endtask
   task automatic t_control();
      w(`PFC_OFS_CONTROL, 32'h33);
      rchk("control", `PFC_OFS_CONTROL, 32'h33);
      repeat (30) @(negedge sys_clk);
      chk("run bypass pattern", {29'h0, run, bypass, pattern}, 32'h7);
      w(`PFC_OFS_CONTROL, 32'h80000000);
      repeat (30) @(negedge sys_clk);
      chk("soft reset", {31'h0, core_reset}, 32'h1);
      w(`PFC_OFS_CONTROL, 32'h0);
      repeat (30) @(negedge sys_clk);
      chk("soft reset released", {31'h0, core_reset}, 32'h0);
      w(`PFC_OFS_CONTROL, 32'h40000000);
      repeat (40) @(negedge sys_clk);
      chk("frame reset", {31'h0, core_reset}, 32'h1);
      repeat (120) @(negedge sys_clk);
      rchk("frame reset cleared", `PFC_OFS_CONTROL, 32'h0);
      chk("frame reset released", {31'h0, core_reset}, 32'h0);
   endtask
   task automatic t_events();
      w(`PFC_OFS_STATUS, 32'hffffffff);
      vpulse(0, 1);
      vpulse(3, 3);
      vpulse(2, 2);
      vpulse(1, 1);
      rchk("status", `PFC_OFS_STATUS, 32'h3);
      rchk("frames", `PFC_OFS_FRAME_CNT, 32'h3);
      rchk("lines", `PFC_OFS_LINE_CNT, 32'h2);
      rchk("pixels", `PFC_OFS_PIXEL_CNT, 32'h3);
      rchk("candidates", `PFC_OFS_CANDIDATES, cand);
      rchk("corrected", `PFC_OFS_CORRECTED, corr);
      w(`PFC_OFS_LINE_CNT, 32'h0);
      rchk("lines after write", `PFC_OFS_LINE_CNT, 32'h2);
      w(`PFC_OFS_STATUS, 32'h1);
      rchk("status one clear", `PFC_OFS_STATUS, 32'h2);
      w(`PFC_OFS_IRQ_MASK, 32'hffffffff);
      rchk("irq enable", `PFC_OFS_IRQ_MASK, `PFC_IRQ_MASK_BITS);
      chk("irq raised", {31'h0, irq}, 32'h1);
      w(`PFC_OFS_IRQ_MASK, 32'h1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      @(negedge aclk);
      fault = 4'h5;
      vpulse(0, 1);
      fault = 4'h0;
      rchk("errors", `PFC_OFS_ERROR, 32'h5);
      rchk("fault summary", `PFC_OFS_STATUS, 32'h10003);
      w(`PFC_OFS_ERROR, 32'h1);
      rchk("error one clear", `PFC_OFS_ERROR, 32'h4);
      w(`PFC_OFS_STATUS, 32'h10003);
      chk("irq cleared", {31'h0, irq}, 32'h0);
   endtask
   task automatic t_freeze();
      aclken = 1'b0;
      fork
         w(`PFC_OFS_AGE, 32'h5a5a);
         begin
            repeat (10)
            begin
               @(negedge sys_clk);
               chk("frozen outputs", {30'h0, awready, bvalid}, 32'h0);
            end
            aclken = 1'b1;
         end
      join
      rchk("age after freeze", `PFC_OFS_AGE, 32'h5a5a);
   endtask
   task automatic t_bus_reset();
      w(`PFC_OFS_CONTROL, 32'h1);
      repeat (30) @(negedge sys_clk);
      chk("core run before reset", {31'h0, run}, 32'h1);
      @(negedge sys_clk);
      aclken = 1'b0;
      aresetn = 1'b0;
      repeat (260) @(negedge sys_clk);
      chk("core run after reset", {31'h0, run}, 32'h0);
      aresetn = 1'b1;
      aclken = 1'b1;
      rchk("control after reset", `PFC_OFS_CONTROL, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      aresetn = 1'b0;
      aclken = 1'b1;
      ev = 4'h0;
      fault = 4'h0;
      cand = 32'h00001234;
      corr = 32'h00000056;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      // Bus reset stays low for more than 32 cycles of the slower video clock.
      repeat (260) @(negedge sys_clk);
      aresetn = 1'b1;
      t_reset_values();
      t_commit();
      t_control();
      t_events();
      t_freeze();
      t_bus_reset();
      report_and_stop();
   end
endmodule
